// [common/wpec_pkg.sv]
// constants for the watchdog and port event block: offsets, fields, reset values, timing
// assumes one 100 MHz clock and a register port fed by the serial front end
// Overview of operation
// - interval register resets to ff, a 255 second time-out
// - each interval count is one second; 01 gives one second
// - a zero interval keeps the timer from counting even when enabled
// - action field bits 2:1: 00 flag, 01 flag and reset, 1x flag and stop
// - control bit 0 enables the watchdog and resets to zero
// - all three actions report through one shared watchdog flag
// - flag-only action just sets the watchdog flag
// - reset action sets the flag and defaults all registers; flag stays set
// - stop action sets the flag and forces coil outputs low until flag clears
// - being addressed restarts the count; host must do so each interval
// - direction bits 3:0: 1 input high impedance, 0 output; inputs after reset
// - bits 7:4 give output levels, reset to zero
// - edge bits 3:0: 1 falling, 0 rising, rising by default
// - filter bits 6:4 reject glitches on pins 0 and 1, 500 us by default
// - selected edge on unmasked pin sets its status flag
// - masked source raises no flag, edge select has no effect
// - mask bits 4:0 reset to one; writing zero enables the source
// - mask bit 4 for motor stopped, bits 3:0 for pins 3:0
// - power-up clears every latch and every flag
// - interrupt pin also gated by the mode register disable bit
// - any read or write of the status register clears its flags
// - motor-stopped event on run bit falling from one to zero
package wpec_pkg;
  localparam logic [5:0] ADDR_WD_INTERVAL = 6'h01;
  localparam logic [5:0] ADDR_WD_CONTROL = 6'h02;
  localparam logic [5:0] ADDR_PORT_CFG = 6'h03;
  localparam logic [5:0] ADDR_EDGE_FILT = 6'h04;
  localparam logic [5:0] ADDR_EVENT_MASK = 6'h05;
  localparam logic [5:0] ADDR_EVENT_STATUS = 6'h06;
  localparam logic [7:0] RST_WD_INTERVAL = 8'hff;
  localparam logic [2:0] RST_WD_CONTROL = 3'h0;
  localparam logic [7:0] RST_PORT_CFG = 8'h0f;
  localparam logic [6:0] RST_EDGE_FILT = 7'h10;
  localparam logic [4:0] RST_EVENT_MASK = 5'h1f;
  localparam int WD_ENABLE_POS = 0;
  localparam int WD_ACTION_LSB = 1;
  localparam int FILT_LSB = 4;
  localparam int STAT_MOTOR_POS = 4;
  localparam int STAT_WD_POS = 5;
  localparam logic [1:0] ACT_FLAG = 2'h0;
  localparam logic [1:0] ACT_RESET = 2'h1;
  localparam int CLK_HZ = 100_000_000;
  localparam int WD_TICK_S = 1;
  localparam int FILT_A_US = 500;
  localparam int FILT_B_US = 1000;
  localparam int FILT_C_US = 5000;
  localparam int FILT_D_US = 10000;
  localparam int WD_TICK_CYCLES = WD_TICK_S * CLK_HZ;
  localparam int FILT_A_CYCLES = FILT_A_US * (CLK_HZ / 1_000_000);
  localparam int FILT_B_CYCLES = FILT_B_US * (CLK_HZ / 1_000_000);
  localparam int FILT_C_CYCLES = FILT_C_US * (CLK_HZ / 1_000_000);
  localparam int FILT_D_CYCLES = FILT_D_US * (CLK_HZ / 1_000_000);
endpackage

// [rtl/wpec_core.sv]
// watchdog timer, port direction/levels, edge events with filter and event mask
// assumes a same-clock register port from the serial slave and a feed pulse from it
`timescale 1ns/1ps
module wpec_core #(
  parameter int unsigned TICK_CYCLES = wpec_pkg::WD_TICK_CYCLES,
  parameter int unsigned FILT_A = wpec_pkg::FILT_A_CYCLES,
  parameter int unsigned FILT_B = wpec_pkg::FILT_B_CYCLES,
  parameter int unsigned FILT_C = wpec_pkg::FILT_C_CYCLES,
  parameter int unsigned FILT_D = wpec_pkg::FILT_D_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic wd_feed,
  input wire logic motor_run,
  input wire logic mode_int_disable,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic int_n_out,
  output logic int_n_oe,
  output logic motor_force_off,
  output logic wd_reset_out,
  output logic [5:0] event_status
);
  import wpec_pkg::*;

  logic [7:0] watchdog_interval;
  logic [2:0] watchdog_control;
  logic [7:0] port_direction_levels;
  logic [6:0] edge_and_filter_select;
  logic [4:0] event_mask;
  logic [7:0] wd_count;
  logic [31:0] presc;
  logic wd_tick;
  logic wd_active;
  logic wd_timeout;
  logic cfg_reset;
  logic status_access;
  logic [1:0] watchdog_action_select;
  logic watchdog_enable_bit;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] filt;
  logic [3:0] filt_prev;
  logic [3:0] pin_edge;
  logic [31:0] filt_limit;
  logic motor_run_prev;
  logic motor_stop_evt;
  logic [5:0] next_status;

  assign watchdog_enable_bit = watchdog_control[WD_ENABLE_POS];
  assign watchdog_action_select = watchdog_control[WD_ACTION_LSB +: 2];
  // a zero interval never arms the timer
  assign wd_active = watchdog_enable_bit && (watchdog_interval != 8'h00);
  assign wd_tick = (presc == TICK_CYCLES - 1);
  // a feed in the expiry cycle wins, so a late but valid feed still rescues the host
  assign wd_timeout = wd_active && wd_tick && (wd_count == 8'h01) && !wd_feed;
  // reset action reloads all registers
  assign cfg_reset = wd_timeout && (watchdog_action_select == ACT_RESET);
  assign status_access = (reg_wr || reg_rd) && (reg_addr == ADDR_EVENT_STATUS);

  // registers written by the host; a watchdog reset overrides any write in flight
  always_ff @(posedge clock) begin
    if (!resetn || cfg_reset) begin
      watchdog_interval <= RST_WD_INTERVAL;
      watchdog_control <= RST_WD_CONTROL;
      port_direction_levels <= RST_PORT_CFG;
      edge_and_filter_select <= RST_EDGE_FILT;
      event_mask <= RST_EVENT_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_WD_INTERVAL: watchdog_interval <= reg_wdata;
        ADDR_WD_CONTROL: watchdog_control <= reg_wdata[2:0];
        ADDR_PORT_CFG: port_direction_levels <= reg_wdata;
        ADDR_EDGE_FILT: edge_and_filter_select <= reg_wdata[6:0];
        ADDR_EVENT_MASK: event_mask <= reg_wdata[4:0];
        default: watchdog_interval <= watchdog_interval;
      endcase
    end
  end

  // read data is registered, so it appears one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_WD_INTERVAL: reg_rdata <= watchdog_interval;
        ADDR_WD_CONTROL: reg_rdata <= {5'h00, watchdog_control};
        ADDR_PORT_CFG: reg_rdata <= port_direction_levels;
        ADDR_EDGE_FILT: reg_rdata <= {1'b0, edge_and_filter_select};
        ADDR_EVENT_MASK: reg_rdata <= {3'h0, event_mask};
        ADDR_EVENT_STATUS: reg_rdata <= {2'h0, event_status};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // one-second prescaler, restarted on each reload so every count is a full second
  always_ff @(posedge clock) begin
    if (!resetn || !wd_active || wd_feed || wd_tick) begin
      presc <= 32'h0;
    end else begin
      presc <= presc + 32'h1;
    end
  end

  // seconds remaining; reloads on feed and after each expiry
  always_ff @(posedge clock) begin
    if (!resetn || cfg_reset) begin
      wd_count <= RST_WD_INTERVAL;
    end else if (!wd_active || wd_feed) begin
      wd_count <= watchdog_interval;
    end else if (wd_tick) begin
      wd_count <= (wd_count == 8'h01) ? watchdog_interval : wd_count - 8'h01;
    end
  end

  // coils held low from a stop-action expiry until the watchdog flag is cleared
  always_ff @(posedge clock) begin
    if (!resetn) begin
      motor_force_off <= 1'b0;
    end else if (wd_timeout && watchdog_action_select[1]) begin
      motor_force_off <= 1'b1;
    end else if (!event_status[STAT_WD_POS]) begin
      motor_force_off <= 1'b0;
    end
  end

  // pulse to the rest of the chip so its registers also return to defaults
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wd_reset_out <= 1'b0;
    end else begin
      wd_reset_out <= cfg_reset;
    end
  end

  // two-stage synchroniser; only the second stage is read
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // glitch width in cycles from the filter field
  always_comb begin
    case (edge_and_filter_select[FILT_LSB +: 3])
      3'h0: filt_limit = 32'h0;
      3'h1: filt_limit = FILT_A;
      3'h2: filt_limit = FILT_B;
      3'h3: filt_limit = FILT_C;
      default: filt_limit = FILT_D;
    endcase
  end

  // per-pin filter and edge select; pins 2 and 3 pass straight through
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      logic [31:0] stable_cnt;
      if (gi < 2) begin : g_filt
        // a change must persist for the whole glitch width before it is accepted
        always_ff @(posedge clock) begin
          if (!resetn) begin
            stable_cnt <= 32'h0;
            filt[gi] <= 1'b0;
          end else if (sync_b[gi] == filt[gi]) begin
            stable_cnt <= 32'h0;
          end else if (stable_cnt + 32'h1 >= filt_limit) begin
            stable_cnt <= 32'h0;
            filt[gi] <= sync_b[gi];
          end else begin
            stable_cnt <= stable_cnt + 32'h1;
          end
        end
      end else begin : g_nofilt
        assign stable_cnt = 32'h0;
        always_ff @(posedge clock) begin
          if (!resetn) begin
            filt[gi] <= 1'b0;
          end else begin
            filt[gi] <= sync_b[gi];
          end
        end
      end
      // falling edge when the select bit is one, rising otherwise
      assign pin_edge[gi] = edge_and_filter_select[gi] ? (filt_prev[gi] && !filt[gi])
                                                       : (!filt_prev[gi] && filt[gi]);
      // output driver enabled only for pins set as outputs
      assign pin_oe[gi] = !port_direction_levels[gi];
      assign pin_out[gi] = port_direction_levels[gi + 4];
    end
  endgenerate

  // previous filtered level and run bit for edge detection
  always_ff @(posedge clock) begin
    if (!resetn) begin
      filt_prev <= 4'h0;
      motor_run_prev <= 1'b0;
    end else begin
      filt_prev <= filt;
      motor_run_prev <= motor_run;
    end
  end

  assign motor_stop_evt = motor_run_prev && !motor_run;

  // new events set flags even in the clearing cycle; masked sources stay silent
  always_comb begin
    next_status = status_access ? 6'h00 : event_status;
    next_status[3:0] = next_status[3:0] | (pin_edge & ~event_mask[3:0]);
    next_status[STAT_MOTOR_POS] = next_status[STAT_MOTOR_POS] ||
                                  (motor_stop_evt && !event_mask[4]);
    next_status[STAT_WD_POS] = next_status[STAT_WD_POS] || wd_timeout;
  end

  // watchdog reset keeps only its own flag set; power-up clears all
  always_ff @(posedge clock) begin
    if (!resetn) begin
      event_status <= 6'h00;
    end else if (cfg_reset) begin
      event_status <= 6'h20;
    end else begin
      event_status <= next_status;
    end
  end

  // open-drain interrupt, pulled low while any flag is set and the pin is enabled
  assign int_n_out = 1'b0;
  assign int_n_oe = (event_status != 6'h00) && !mode_int_disable;

  sequence s_stop_expiry;
    wd_timeout && watchdog_action_select[1];
  endsequence

  sequence s_forced_until_clear;
    motor_force_off [*1] ##1 motor_force_off;
  endsequence

  property p_reset_defaults;
    @(posedge clock) disable iff (!resetn)
      cfg_reset |=> (watchdog_interval == 8'hff) && (event_mask == 5'h1f) &&
                    (port_direction_levels == 8'h0f) && event_status[5] &&
                    (event_status[4:0] == 5'h00) && wd_reset_out;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset action lost");

  property p_zero_interval;
    @(posedge clock) disable iff (!resetn)
      (watchdog_interval == 8'h00) |-> !wd_timeout ##1 (presc == 32'h0);
  endproperty
  a_zero_interval: assert property (p_zero_interval) else $error("zero interval ran");

  property p_stop_force;
    @(posedge clock) disable iff (!resetn)
      s_stop_expiry |=> motor_force_off && event_status[5];
  endproperty
  a_stop_force: assert property (p_stop_force) else $error("stop action missed");

  property p_force_needs_flag;
    @(posedge clock) disable iff (!resetn)
      s_forced_until_clear |-> $past(event_status[5] || wd_timeout);
  endproperty
  a_force_needs_flag: assert property (p_force_needs_flag) else $error("forced w/o flag");

  property p_flag_only;
    @(posedge clock) disable iff (!resetn)
      (wd_timeout && watchdog_action_select == ACT_FLAG && !motor_force_off)
        |=> event_status[5] && !motor_force_off && !wd_reset_out;
  endproperty
  a_flag_only: assert property (p_flag_only) else $error("flag-only action wrong");

  property p_feed_reload;
    @(posedge clock) disable iff (!resetn)
      (wd_active && wd_feed && !reg_wr) |=> (wd_count == $past(watchdog_interval)) ##1
        (presc == 32'h1 || !wd_active || $past(wd_feed));
  endproperty
  a_feed_reload: assert property (p_feed_reload) else $error("feed did not reload");

  property p_tick_dec;
    @(posedge clock) disable iff (!resetn)
      (wd_active && wd_tick && !wd_feed && wd_count > 8'h01 && !reg_wr)
        |=> wd_count == $past(wd_count) - 8'h01;
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("count not decremented");

  property p_pin_event;
    @(posedge clock) disable iff (!resetn)
      (pin_edge[0] && !event_mask[0] && !cfg_reset) |=> event_status[0];
  endproperty
  a_pin_event: assert property (p_pin_event) else $error("pin event lost");

  property p_masked_clear;
    @(posedge clock) disable iff (!resetn)
      (status_access && event_mask == 5'h1f && !wd_timeout)
        |=> (event_status == 6'h00) ##1 (event_status[4:0] == 5'h00 || event_mask != 5'h1f);
  endproperty
  a_masked_clear: assert property (p_masked_clear) else $error("masked source flagged");

  property p_motor_stop;
    @(posedge clock) disable iff (!resetn)
      ($fell(motor_run) && !event_mask[4] && !cfg_reset) |=> event_status[4];
  endproperty
  a_motor_stop: assert property (p_motor_stop) else $error("motor stop missed");

  property p_int_gate;
    @(posedge clock) disable iff (!resetn)
      int_n_oe |-> !mode_int_disable && (event_status != 6'h00);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("interrupt not gated");

  property p_dir_oe;
    @(posedge clock) disable iff (!resetn)
      (reg_wr && reg_addr == ADDR_PORT_CFG && !cfg_reset)
        |=> pin_oe == ~$past(reg_wdata[3:0]) && pin_out == $past(reg_wdata[7:4]);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("port config not applied");

  // a latched flag may only drop through a status access or the watchdog reset
  property p_flag_hold;
    @(posedge clock) disable iff (!resetn)
      (event_status != 6'h00 && !status_access && !cfg_reset)
        |=> ((event_status & $past(event_status)) == $past(event_status));
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped early");

  // the coil override lets go one cycle after the watchdog flag is gone
  property p_force_release;
    @(posedge clock) disable iff (!resetn)
      (!event_status[STAT_WD_POS] && !wd_timeout) |=> !motor_force_off;
  endproperty
  a_force_release: assert property (p_force_release) else $error("force not released");
endmodule

// [testbench/test_watchdog_port_event_control.sv]
// self-checking bench for the watchdog and port event core
// assumes short tick (20) and filter (3,5,7,9) counts so the run stays small
`timescale 1ns/1ps
module test_watchdog_port_event_control;
  import wpec_pkg::*;
  localparam int TICK = 20;
  logic clock = 0;
  logic resetn = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic wd_feed = 0;
  logic motor_run = 0;
  logic mode_int_disable = 0;
  logic [3:0] sensor = 4'h0;
  logic [3:0] pin_in, pin_out, pin_oe;
  logic int_n_out, int_n_oe, motor_force_off, wd_reset_out;
  logic [5:0] event_status;
  logic [7:0] d;
  int fail_count = 0;
  int n_checks = 0;
  int n;

  wpec_core #(.TICK_CYCLES(TICK), .FILT_A(3), .FILT_B(5), .FILT_C(7), .FILT_D(9))
    wpec_core_inst (.clock(clock), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wd_feed(wd_feed),
    .motor_run(motor_run), .mode_int_disable(mode_int_disable), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
    .motor_force_off(motor_force_off), .wd_reset_out(wd_reset_out),
    .event_status(event_status));

  wpec_sensor_model wpec_sensor_model_inst (.sensor_level(sensor), .pin_oe(pin_oe),
    .pin_out(pin_out), .pin_level(pin_in));

  // free-running 100 MHz clock
  always #5 clock = ~clock;

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle strobes on falling edges; an idle cycle follows so that a
  // back-to-back call never raises the strobe in the time step that dropped it
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    @(negedge clock);
    reg_wr = 0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clock);
    reg_rd = 0;
    v = reg_rdata;
    @(negedge clock);
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge clock);
  endtask

  // bounded wait for one status flag; the count feeds timing checks
  task automatic wait_bit(input int idx, input int bound, output int cnt);
    cnt = 0;
    while (event_status[idx] !== 1'b1 && cnt < bound) begin
      @(negedge clock);
      cnt++;
    end
    if (cnt >= bound) begin
      fail_count++;
      $display("BAD wait_bit expected 1 seen 0");
      conclude();
    end
  endtask

  initial begin
    logic [7:0] exp_rst [1:5];
    exp_rst = '{8'hff, 8'h00, 8'h0f, 8'h10, 8'h1f};
    repeat (20) @(negedge clock);
    resetn = 1;
    // reset values and an unmapped read
    for (int a = 1; a <= 5; a++) begin
      rd(a[5:0], d);
      check("reset_reg", d, exp_rst[a]);
    end
    rd(6'h07, d);
    check("unmapped", d, 8'h00);
    rd(6'h06, d);
    check("reset_status", d, 8'h00);
    check("reset_oe", {4'h0, pin_oe}, 8'h00);
    $display("test reset done");
    // direction and output levels
    wr(6'h03, 8'ha5);
    idle(1);
    check("pin_oe", {4'h0, pin_oe}, 8'h0a);
    check("pin_out", {4'h0, pin_out}, 8'h0a);
    check("pin_wire", {4'h0, pin_in & 4'ha}, 8'h0a);
    wr(6'h03, 8'h0f);
    $display("test port done");
    // edges: unfiltered, rising then falling select, masked, filtered
    wr(6'h04, 8'h00);
    wr(6'h05, 8'h00);
    idle(10);
    rd(6'h06, d);
    sensor = 4'h4;
    wait_bit(2, 30, n);
    idle(2);
    rd(6'h06, d);
    check("rise_flag", d, 8'h04);
    check("cleared", {2'b00, event_status}, 8'h00);
    wr(6'h04, 8'h08);
    sensor = 4'hc;
    idle(12);
    check("no_rise_p3", {2'b00, event_status}, 8'h00);
    sensor = 4'h4;
    wait_bit(3, 30, n);
    wr(6'h06, 8'h00);
    check("wr_clear", {2'b00, event_status}, 8'h00);
    wr(6'h05, 8'h04);
    sensor = 4'h0;
    idle(10);
    sensor = 4'h4;
    idle(12);
    check("masked", {2'b00, event_status}, 8'h00);
    wr(6'h04, 8'h10);
    wr(6'h05, 8'h00);
    idle(4);
    rd(6'h06, d);
    sensor = 4'h5;
    @(negedge clock);
    sensor = 4'h4;
    idle(15);
    check("glitch", {2'b00, event_status}, 8'h00);
    sensor = 4'h5;
    wait_bit(0, 30, n);
    rd(6'h06, d);
    check("filtered", d, 8'h01);
    $display("test edges done");
    // motor stop event and the pin gate
    wr(6'h05, 8'h0f);
    motor_run = 1;
    idle(4);
    motor_run = 0;
    wait_bit(4, 4, n);
    idle(1);
    check("int_pin", {7'h0, int_n_oe}, 8'h01);
    check("int_data", {7'h0, int_n_out}, 8'h00);
    mode_int_disable = 1;
    #1;
    check("int_gate", {7'h0, int_n_oe}, 8'h00);
    @(negedge clock);
    mode_int_disable = 0;
    rd(6'h06, d);
    check("motor_flag", d, 8'h10);
    wr(6'h05, 8'h1f);
    $display("test motor done");
    // watchdog flag-only: period scales with interval; host clears flag first
    for (int iv = 1; iv <= 2; iv++) begin
      wr(6'h01, iv[7:0]);
      rd(6'h06, d);
      wr(6'h02, 8'h01);
      wait_bit(5, 3 * TICK, n);
      check("wd_period", {7'h0, (n >= iv * TICK - 3 && n <= iv * TICK + 3)}, 8'h01);
      check("wd_only", {2'b00, event_status}, 8'h20);
      wr(6'h02, 8'h00);
      rd(6'h06, d);
    end
    // feeding keeps it quiet; zero interval never starts
    wr(6'h02, 8'h01);
    repeat (10) begin
      idle(9);
      wd_feed = 1;
      @(negedge clock);
      wd_feed = 0;
    end
    check("fed", {2'b00, event_status}, 8'h00);
    wr(6'h01, 8'h00);
    idle(3 * TICK);
    check("zero_iv", {2'b00, event_status}, 8'h00);
    $display("test watchdog done");
    // stop action (both codes 10 and 11) holds the coils off until the flag clears
    for (int m = 0; m < 2; m++) begin
      wr(6'h02, 8'h00);
      wr(6'h01, 8'h01);
      wr(6'h02, (m == 0) ? 8'h05 : 8'h07);
      wait_bit(5, 3 * TICK, n);
      idle(2);
      check("force_off", {7'h0, motor_force_off}, 8'h01);
      wr(6'h02, 8'h00);
      idle(5);
      check("force_held", {7'h0, motor_force_off}, 8'h01);
      rd(6'h06, d);
      idle(1);
      check("force_rel", {7'h0, motor_force_off}, 8'h00);
    end
    // reset action returns registers to defaults and keeps the flag
    wr(6'h03, 8'ha5);
    wr(6'h02, 8'h03);
    wait_bit(5, 3 * TICK, n);
    check("wd_rst_pulse", {7'h0, wd_reset_out}, 8'h01);
    idle(2);
    rd(6'h03, d);
    check("rst_cfg", d, 8'h0f);
    rd(6'h02, d);
    check("rst_ctl", d, 8'h00);
    rd(6'h06, d);
    check("rst_flag", d, 8'h20);
    rd(6'h06, d);
    check("rst_flag_clr", d, 8'h00);
    $display("test actions done");
    conclude();
  end
endmodule

// [testbench/wpec_sensor_model.sv]
// far-side pin model: optical sensors on the four port pins
// assumes the bench sets sensor levels; a pin the block drives shows its level
`timescale 1ns/1ps
module wpec_sensor_model (
  input wire logic [3:0] sensor_level,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] pin_out,
  output logic [3:0] pin_level
);
  // an input pin is high impedance on the block side, so the sensor wins
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : sensor_level[i];
    end
  end
endmodule
